// File: hdl/hfc_map.vh
`ifndef HFC_MAP_VH
`define HFC_MAP_VH
// Register byte offsets
`define HFC_OFF_CTRL     8'h00
`define HFC_OFF_CMD      8'h04
`define HFC_OFF_COUNTS   8'h08
`define HFC_OFF_STATUS   8'h0C
`define HFC_OFF_BAND0    8'h10
`define HFC_OFF_RANGE0   8'h40
`define HFC_NUM_BANDS    5
`define HFC_NUM_RANGES   8
// Field kinds
`define HFC_KIND_BAND    2'h0
`define HFC_KIND_PROBE   2'h1
`define HFC_KIND_CLREQ   2'h2
`define HFC_KIND_CLIST   2'h3
// Status bit positions
`define HFC_ST_BUSY      0
`define HFC_ST_CFG_ERR   1
`define HFC_ST_RX_RANGE  2
`define HFC_ST_RX_COUNT  3
`define HFC_ST_RX_MODE   4
// Level-2 octet bit positions
`define HFC_L2_TRAIN     0
`define HFC_L2_PROBE     1
`define HFC_L2_SILENT    2
// Value limits
`define HFC_PROBE_LO     7'h04
`define HFC_PROBE_HI     7'h59
`define HFC_STEP_LO      7'h01
`define HFC_STEP_HI      7'h59
`define HFC_T16_LO       7'h03
`define HFC_T16_HI       7'h3C
`define HFC_T32_LO       7'h0C
`define HFC_T32_HI       7'h59
`define HFC_CNT_SINGLE   4'h1
`define HFC_CNT_LO       4'h2
`define HFC_CNT_HI       4'h8
`define HFC_NB_LO        3'h1
`define HFC_NB_HI        3'h5
// Reset values
`define HFC_CTRL_RST     32'h0000_0040
`define HFC_COUNTS_RST   32'h0011_1111
`endif

// File: hdl/hfc_codec.v
// Our own choices: the register addresses and register access over APB.
`include "hfc_map.vh"

// Octet FIFO between framer and link side
module hfc_fifo #(
    parameter W  = 8,
    parameter D  = 16,
    parameter AW = 4
) (
    input  wire          clk_sys,
    input  wire          rst,
    input  wire [W-1:0]  in_data,
    input  wire          in_valid,
    output wire          in_ready,
    output reg  [W-1:0]  out_data,
    output wire          out_valid,
    input  wire          out_ready
);
    reg  [W-1:0] mem_r [0:D-1];
    reg  [AW-1:0] wp_r;
    reg  [AW-1:0] rp_r;
    reg  [AW:0]   cnt_r;
    wire          push;
    wire          pop;

    assign in_ready  = (cnt_r != D[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @* begin
        out_data = mem_r[rp_r];
    end

    always @(posedge clk_sys) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
        if (rst) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // hfc_fifo

// Summary of operation
// - Band end tone index: bits 12..7 in octet 4n-3, bits 6..1 in 4n-2.
// - Band start tone index: bits 12..7 in octet 4n-1, bits 6..1 in 4n.
// - Band index runs 1 to 5, four consecutive octets per band.
// - Line-probe minimum and maximum rates sent only within 4 to 89.
// - Every step value sent lies within 1 to 89.
// - Both line-probe range counts independent, each 2 to 8.
// - Single line-probe range sends only first minimum, maximum, step octets.
// - Capability minimum/maximum within 3-60 for 16-TCPAM, 12-89 for 32-TCPAM.
// - Four training range counts independent, each 2 to 8.
// - Capability single range sends first octets; else count times four octets.
// - Training mode and line-probe mode bits never both set.
// - Silent-period bit forced 0 when either mode bit is 1.
// - Band list field length is four octets per described band.
module hfc_codec #(
    parameter AW_APB = 8,
    parameter FDEPTH = 16,
    parameter FAW    = 4
) (
    input  wire              clk_sys,
    input  wire              rst,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [AW_APB-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output reg               pslverr,
    output wire [7:0]        tx_octet,
    output wire              tx_valid,
    input  wire              tx_ready,
    input  wire              rx_chk_stb,
    input  wire [1:0]        rx_chk_kind,
    input  wire              rx_chk_tcpam32,
    input  wire [6:0]        rx_chk_min,
    input  wire [6:0]        rx_chk_max,
    input  wire [6:0]        rx_chk_step,
    input  wire [3:0]        rx_chk_count,
    input  wire              rx_chk_train,
    input  wire              rx_chk_probe,
    output reg               rx_chk_bad
);
    localparam ST_IDLE = 1'b0;
    localparam ST_EMIT = 1'b1;

    reg  [31:0] ctrl_r;
    reg  [31:0] counts_r;
    reg  [4:1]  err_r;
    reg  [27:0] band_r [0:`HFC_NUM_BANDS-1];
    reg  [22:0] rng_r  [0:`HFC_NUM_RANGES-1];
    reg         st_r;
    reg  [5:0]  idx_r;
    reg  [5:0]  len_r;
    reg  [7:0]  oct_nxt;
    reg  [5:0]  len_nxt;
    reg  [31:0] rd_nxt;
    reg         rd_err_nxt;
    reg  [4:1]  err_nxt;
    reg  [2:0]  bsel;
    reg  [2:0]  rsel;
    reg  [1:0]  osel;
    reg  [5:0]  j;
    integer     i;
    wire [1:0]  kind   = ctrl_r[1:0];
    wire        t32    = ctrl_r[2];
    wire        m_trn  = ctrl_r[3];
    wire        m_prb  = ctrl_r[4];
    wire        silent = ctrl_r[5];
    wire [2:0]  nbands = ctrl_r[8:6];
    wire [3:0]  cnt_pa = counts_r[3:0];
    wire [3:0]  cnt_pb = counts_r[7:4];
    wire [3:0]  cnt_ta = counts_r[11:8];
    wire [3:0]  cnt_use = (kind == `HFC_KIND_PROBE) ? cnt_pa : cnt_ta;
    wire        wr_acc = psel & penable & pwrite;
    wire        setup  = psel & ~penable;
    wire [7:0]  addr8  = paddr[7:0];
    wire        start  = wr_acc & (addr8 == `HFC_OFF_CMD) & pwdata[0] & (st_r == ST_IDLE);
    function cnt_ok;
        input [3:0] c;
        begin
            cnt_ok = (c == `HFC_CNT_SINGLE) | ((c >= `HFC_CNT_LO) & (c <= `HFC_CNT_HI));
        end
    endfunction
    function val_ok;
        input [1:0] k;
        input       w32;
        input [6:0] v;
        begin
            if (k == `HFC_KIND_PROBE) begin
                val_ok = (v >= `HFC_PROBE_LO) & (v <= `HFC_PROBE_HI);
            end else if (w32) begin
                val_ok = (v >= `HFC_T32_LO) & (v <= `HFC_T32_HI);
            end else begin
                val_ok = (v >= `HFC_T16_LO) & (v <= `HFC_T16_HI);
            end
        end
    endfunction
    function step_ok;
        input [6:0] v;
        begin
            step_ok = (v >= `HFC_STEP_LO) & (v <= `HFC_STEP_HI);
        end
    endfunction
    // Per-entry range validity
    wire [`HFC_NUM_RANGES-1:0] rng_ok;
    genvar g;
    generate
        for (g = 0; g < `HFC_NUM_RANGES; g = g + 1) begin : g_rng
            wire mm_ok = val_ok(kind, t32, rng_r[g][6:0]) & val_ok(kind, t32, rng_r[g][14:8]);
            wire s_ok  = step_ok(rng_r[g][22:16]);
            assign rng_ok[g] = (g >= cnt_use) | (mm_ok & s_ok);
        end
    endgenerate

    wire counts_ok = cnt_ok(cnt_pa) & cnt_ok(cnt_pb) & cnt_ok(cnt_ta)
                   & cnt_ok(counts_r[15:12]) & cnt_ok(counts_r[19:16])
                   & cnt_ok(counts_r[23:20]);
    wire mode_ok = ~(m_trn & m_prb);
    wire band_ok = (nbands >= `HFC_NB_LO) & (nbands <= `HFC_NB_HI);
    wire cfg_ok  = mode_ok & ((kind == `HFC_KIND_BAND) ? band_ok : (counts_ok & (&rng_ok)));

    // Frame length
    always @* begin
        if (kind == `HFC_KIND_BAND) begin
            len_nxt = {1'b0, nbands, 2'b00} + 6'h01;
        end else if (cnt_use == `HFC_CNT_SINGLE) begin
            len_nxt = 6'h04;
        end else begin
            len_nxt = {cnt_use, 2'b00} + 6'h01;
        end
    end

    // Octet at current index
    always @* begin
        j    = idx_r - 6'h01;
        bsel = j[4:2];
        osel = j[1:0];
        rsel = j[4:2];
        oct_nxt = 8'h00;
        if (idx_r == 6'h00) begin
            oct_nxt[`HFC_L2_TRAIN]  = m_trn;
            oct_nxt[`HFC_L2_PROBE]  = m_prb;
            oct_nxt[`HFC_L2_SILENT] = silent & ~m_trn & ~m_prb;
        end else if (kind == `HFC_KIND_BAND) begin
            case (osel)
                2'd0: oct_nxt = {2'b00, band_r[bsel][27:22]};
                2'd1: oct_nxt = {2'b00, band_r[bsel][21:16]};
                2'd2: oct_nxt = {2'b00, band_r[bsel][11:6]};
                default: oct_nxt = {2'b00, band_r[bsel][5:0]};
            endcase
        end else begin
            if (cnt_use == `HFC_CNT_SINGLE) begin
                rsel = 3'd0;
            end
            case (osel)
                2'd0: oct_nxt = {1'b0, rng_r[rsel][6:0]};
                2'd1: oct_nxt = {1'b0, rng_r[rsel][14:8]};
                2'd2: oct_nxt = {1'b0, rng_r[rsel][22:16]};
                default: oct_nxt = 8'h00;
            endcase
        end
    end
    wire       f_ready;
    wire       f_valid = (st_r == ST_EMIT);
    hfc_fifo #(
        .W  (8),
        .D  (FDEPTH),
        .AW (FAW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_data   (oct_nxt),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .out_data  (tx_octet),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // Framer
    always @(posedge clk_sys) begin
        if (rst) begin
            st_r  <= ST_IDLE;
            idx_r <= 6'h00;
            len_r <= 6'h00;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (start & cfg_ok) begin
                        st_r  <= ST_EMIT;
                        idx_r <= 6'h00;
                        len_r <= len_nxt;
                    end
                end
                default: begin
                    if (f_ready) begin
                        if (idx_r == len_r - 6'h01) begin
                            st_r <= ST_IDLE;
                        end else begin
                            idx_r <= idx_r + 6'h01;
                        end
                    end
                end
            endcase
        end
    end

    wire rx_range_bad = ~val_ok(rx_chk_kind, rx_chk_tcpam32, rx_chk_min)
                      | ~val_ok(rx_chk_kind, rx_chk_tcpam32, rx_chk_max)
                      | ~step_ok(rx_chk_step);
    wire rx_count_bad = ~cnt_ok(rx_chk_count);
    wire rx_mode_bad  = rx_chk_train & rx_chk_probe;
    wire rx_rate      = rx_chk_kind != `HFC_KIND_BAND;

    // Sticky errors, set beats clear
    always @* begin
        err_nxt = err_r;
        if (wr_acc & (addr8 == `HFC_OFF_STATUS)) begin
            err_nxt = err_r & ~pwdata[4:1];
        end
        if (start & ~cfg_ok) begin
            err_nxt[`HFC_ST_CFG_ERR] = 1'b1;
        end
        if (rx_chk_stb) begin
            if (rx_rate & rx_range_bad) begin
                err_nxt[`HFC_ST_RX_RANGE] = 1'b1;
            end
            if (rx_rate & rx_count_bad) begin
                err_nxt[`HFC_ST_RX_COUNT] = 1'b1;
            end
            if (rx_mode_bad) begin
                err_nxt[`HFC_ST_RX_MODE] = 1'b1;
            end
        end
    end

    // Read mux
    always @* begin
        rd_nxt     = 32'h0000_0000;
        rd_err_nxt = 1'b0;
        if (addr8 == `HFC_OFF_CTRL) begin
            rd_nxt = ctrl_r;
        end else if (addr8 == `HFC_OFF_CMD) begin
            rd_nxt = 32'h0000_0000;
        end else if (addr8 == `HFC_OFF_COUNTS) begin
            rd_nxt = counts_r;
        end else if (addr8 == `HFC_OFF_STATUS) begin
            rd_nxt = {27'h000_0000, err_r, st_r};
        end else if ((addr8 >= `HFC_OFF_BAND0) && (addr8 < `HFC_OFF_BAND0 + 8'h14)
                     && (addr8[1:0] == 2'b00)) begin
            rd_nxt = {4'h0, band_r[addr8[4:2] - 3'd4]};
        end else if ((addr8 >= `HFC_OFF_RANGE0) && (addr8 < `HFC_OFF_RANGE0 + 8'h20)
                     && (addr8[1:0] == 2'b00)) begin
            rd_nxt = {9'h000, rng_r[addr8[4:2]]};
        end else begin
            rd_err_nxt = 1'b1;
        end
    end
    assign pready = 1'b1;
    // APB slave registers
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl_r   <= `HFC_CTRL_RST;
            counts_r <= `HFC_COUNTS_RST;
            err_r    <= 4'h0;
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
            rx_chk_bad <= 1'b0;
            for (i = 0; i < `HFC_NUM_BANDS; i = i + 1) begin
                band_r[i] <= 28'h000_0000;
            end
            for (i = 0; i < `HFC_NUM_RANGES; i = i + 1) begin
                rng_r[i] <= 23'h00_0000;
            end
        end else begin
            err_r      <= err_nxt;
            rx_chk_bad <= rx_chk_stb & ((rx_rate & (rx_range_bad | rx_count_bad)) | rx_mode_bad);
            if (setup) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
                pslverr <= rd_err_nxt;
            end
            if (wr_acc & ~pslverr) begin
                if (addr8 == `HFC_OFF_CTRL) begin
                    ctrl_r <= {23'h00_0000, pwdata[8:0]};
                end else if (addr8 == `HFC_OFF_COUNTS) begin
                    counts_r <= {8'h00, pwdata[23:0]};
                end else if ((addr8 >= `HFC_OFF_BAND0) && (addr8 < `HFC_OFF_RANGE0)) begin
                    band_r[addr8[4:2] - 3'd4] <= {pwdata[27:16], 4'h0, pwdata[11:0]};
                end else if (addr8 >= `HFC_OFF_RANGE0) begin
                    rng_r[addr8[4:2]] <= {pwdata[22:16], 1'b0, pwdata[14:8], 1'b0, pwdata[6:0]};
                end
            end
        end
    end
endmodule // hfc_codec

// File: testbench/hfc_codec_sva.sv
module hfc_codec_sva (
    input logic       clk_sys,
    input logic       rst,
    input logic [7:0] tx_octet,
    input logic       tx_valid,
    input logic       tx_ready,
    input logic       rx_chk_stb,
    input logic [1:0] rx_chk_kind,
    input logic       rx_chk_tcpam32,
    input logic [6:0] rx_chk_min,
    input logic [6:0] rx_chk_max,
    input logic [6:0] rx_chk_step,
    input logic [3:0] rx_chk_count,
    input logic       rx_chk_train,
    input logic       rx_chk_probe,
    input logic       rx_chk_bad
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    mode_clash_a: assert property (
        rx_chk_stb && rx_chk_train && rx_chk_probe |=> rx_chk_bad) else $error("mode clash missed");
    bad_cause_a: assert property (
        rx_chk_bad |-> $past(rx_chk_stb)) else $error("bad without strobe");
    probe_low_a: assert property (
        rx_chk_stb && rx_chk_kind == 2'h1 && rx_chk_min < 7'h04 |=> rx_chk_bad)
        else $error("low probe rate missed");
    step_zero_a: assert property (
        rx_chk_stb && rx_chk_kind != 2'h0 && rx_chk_step == 7'h00 |=> rx_chk_bad)
        else $error("zero step missed");
    count_high_a: assert property (
        rx_chk_stb && rx_chk_kind != 2'h0 && rx_chk_count > 4'h8 |=> rx_chk_bad)
        else $error("count over eight missed");
    t16_high_a: assert property (
        rx_chk_stb && rx_chk_kind[1] && !rx_chk_tcpam32 && rx_chk_max > 7'h3C |=> rx_chk_bad)
        else $error("16 level max missed");
    good_probe_a: assert property (
        rx_chk_stb && !rx_chk_train && rx_chk_kind == 2'h1 && rx_chk_min inside {[4:89]}
        && rx_chk_max inside {[4:89]} && rx_chk_step inside {[1:89]}
        && rx_chk_count inside {[1:8]} |=> !rx_chk_bad) else $error("good frame flagged");
    octet_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_octet)) else $error("octet dropped");
endmodule // hfc_codec_sva

bind hfc_codec hfc_codec_sva SVA (.*);

// File: testbench/hfc_peer.sv
module hfc_peer (
    input  logic       clk_sys,
    input  logic       rst,
    input  logic [7:0] tx_octet,
    input  logic       tx_valid,
    input  logic       stall,
    output logic       tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph_r = 2'h0;
    logic [7:0] got[$];
    always @(posedge clk_sys) begin
        ph_r <= rst ? 2'h0 : ph_r + 2'h1;
        tx_ready <= !rst && !stall && ph_r != 2'h3;
        if (!rst && tx_valid && tx_ready)
            got.push_back(tx_octet);
    end
endmodule // hfc_peer

// File: testbench/hfc_codec_test.sv
`include "hfc_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t mismatch %h vs %h", $time, a, b); end end
module hfc_codec_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'h0, rst = 1'h1, stall = 1'h0, er, w;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00, tx_octet;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, tx_valid, tx_ready, rx_chk_bad;
    logic        rx_chk_stb = 1'h0, rx_chk_tcpam32 = 1'h0, rx_chk_train = 1'h0;
    logic        rx_chk_probe = 1'h0;
    logic [1:0]  rx_chk_kind = 2'h0, kd;
    logic [6:0]  rx_chk_min = 7'h0, rx_chk_max = 7'h0, rx_chk_step = 7'h0, mn, mx, st;
    logic [3:0]  rx_chk_count = 4'h0;
    logic [11:0] te, ts;
    logic [7:0]  q[$];
    logic [31:0] seed = 32'h0000_6067;
    int          err_total = 0, checked = 0, k, j, c, lo, hi, cn;
    hfc_codec DUT (.*);
    hfc_peer PEER (.*);
    initial forever #10 clk_sys = ~clk_sys;
    function int rnd(input int m);
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed % m;
    endfunction
    function logic bad_exp();
        int l, h;
        l = rx_chk_kind == 2'h1 ? 4 : rx_chk_tcpam32 ? 12 : 3;
        h = rx_chk_kind == 2'h1 || rx_chk_tcpam32 ? 89 : 60;
        if (rx_chk_train && rx_chk_probe) return 1'h1;
        if (rx_chk_kind == 2'h0) return 1'h0;
        return rx_chk_min < l || rx_chk_min > h || rx_chk_max < l || rx_chk_max > h
            || rx_chk_step < 1 || rx_chk_step > 89 || rx_chk_count < 1 || rx_chk_count > 8;
    endfunction
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Prepends the expected level-2 octet, starts the frame, compares the stream
    task frame(input logic [31:0] ctl);
        int n;
        q.push_front({5'h00, ctl[5] & !(ctl[3] | ctl[4]), ctl[4], ctl[3]});
        PEER.got.delete();
        apb(1'h1, `HFC_OFF_CTRL, ctl);
        apb(1'h1, `HFC_OFF_CMD, 32'h1);
        n = 0;
        while (PEER.got.size() < q.size() && n++ < 400) @(posedge clk_sys);
        repeat (20) @(posedge clk_sys);
        `CHK(PEER.got.size(), q.size())
        foreach (q[i]) `CHK(PEER.got[i], q[i])
        q.delete();
    endtask
    task finish_test;
        $display("checked %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'h0;
        apb(1'h0, `HFC_OFF_CTRL, 32'h0);
        `CHK(rd, `HFC_CTRL_RST)
        apb(1'h0, `HFC_OFF_COUNTS, 32'h0);
        `CHK(rd, `HFC_COUNTS_RST)
        apb(1'h1, 8'h30, 32'h1);
        apb(1'h0, 8'h30, 32'h0);
        `CHK({er, rd}, {1'h1, 32'h0})
        $display("test regs done");
        for (k = 1; k <= 5; k++) begin
            for (j = 1; j <= k; j++) begin
                te = rnd(4096);
                ts = j == 1 ? 12'hFFF : rnd(4096);
                apb(1'h1, `HFC_OFF_BAND0 + 4 * (j - 1), {4'h0, te, 4'h0, ts});
                q.push_back({2'h0, te[11:6]});
                q.push_back({2'h0, te[5:0]});
                q.push_back({2'h0, ts[11:6]});
                q.push_back({2'h0, ts[5:0]});
            end
            // Full FIFO while the peer stalls
            if (k == 5) fork
                begin
                    stall <= 1'h1;
                    repeat (60) @(posedge clk_sys);
                    stall <= 1'h0;
                end
            join_none
            frame({23'h0, k[2:0], 1'h1, k == 2, k == 3, 3'h0});
        end
        $display("test band done");
        for (c = 0; c < 4; c++) begin
            kd = c < 2 ? 2'h1 : c;
            cn = c == 0 ? 1 : c == 1 ? 8 : c;
            w = c == 3;
            lo = kd == 2'h1 ? 4 : w ? 12 : 3;
            hi = kd == 2'h1 || w ? 89 : 60;
            for (j = 1; j <= 8; j++) begin
                mn = j == 1 ? lo : lo + rnd(hi - lo + 1);
                mx = j == 1 ? hi : lo + rnd(hi - lo + 1);
                st = j == 1 ? 89 : 1 + rnd(89);
                apb(1'h1, `HFC_OFF_RANGE0 + 4 * (j - 1), {9'h0, st, 1'h0, mx, 1'h0, mn});
                if (j <= cn) begin
                    q.push_back({1'h0, mn});
                    q.push_back({1'h0, mx});
                    q.push_back({1'h0, st});
                    if (cn > 1) q.push_back(8'h00);
                end
            end
            apb(1'h1, `HFC_OFF_COUNTS, kd == 2'h1 ? 32'h0011_1110 | cn : 32'h0011_1011 | cn << 8);
            frame({23'h0, 3'h1, 3'h0, w, kd});
        end
        $display("test rate done");
        for (c = 0; c < 4; c++) begin
            apb(1'h1, `HFC_OFF_RANGE0, c == 1 ? 32'h0001_5903 : c == 2 ? 32'h0000_5904 : 32'h0001_5904);
            apb(1'h1, `HFC_OFF_COUNTS, c == 3 ? 32'h0011_1119 : 32'h0011_1111);
            PEER.got.delete();
            apb(1'h1, `HFC_OFF_CTRL, c == 0 ? 32'h0000_0059 : 32'h0000_0041);
            apb(1'h1, `HFC_OFF_CMD, 32'h1);
            repeat (20) @(posedge clk_sys);
            apb(1'h0, `HFC_OFF_STATUS, 32'h0);
            `CHK({rd[1], PEER.got.size()}, {1'h1, 32'h0})
            apb(1'h1, `HFC_OFF_STATUS, 32'h2);
        end
        $display("test refuse done");
        for (c = 0; c < 80; c++) begin
            @(posedge clk_sys);
            rx_chk_stb <= 1'h1;
            rx_chk_kind <= rnd(4);
            rx_chk_tcpam32 <= rnd(2);
            rx_chk_min <= rnd(96);
            rx_chk_max <= rnd(96);
            rx_chk_step <= rnd(92);
            rx_chk_count <= rnd(10);
            rx_chk_train <= rnd(3) == 0;
            rx_chk_probe <= rnd(3) == 0;
            @(posedge clk_sys);
            rx_chk_stb <= 1'h0;
            @(negedge clk_sys);
            `CHK(rx_chk_bad, bad_exp())
        end
        // Mode clash alone sets only its sticky bit
        apb(1'h1, `HFC_OFF_STATUS, 32'h0000_001E);
        @(posedge clk_sys);
        rx_chk_stb <= 1'h1;
        rx_chk_kind <= `HFC_KIND_BAND;
        rx_chk_train <= 1'h1;
        rx_chk_probe <= 1'h1;
        @(posedge clk_sys);
        rx_chk_stb <= 1'h0;
        apb(1'h0, `HFC_OFF_STATUS, 32'h0);
        `CHK(rd[4:0], 5'h10)
        $display("test rx done");
        finish_test();
    end
endmodule // hfc_codec_test
